// ---- core/cnms_supervisor.sv ----
/*
  nmt state machine, boot-up, node guarding, heartbeat producer, parameter
  save and restore, layer setting node id for one canopen slave node.
  assumes a can frame layer that decodes nmt, guard polls, lss and object
  writes into one-cycle strobes, and that sends the error-control frame
  offered on ec_valid_o when ec_ready_i is high.
*/
`timescale 1ns/100ps
`include "cnms_map.svh"
// Notes on behaviour
// RULE1: operational: fully active, pdo and emergency sending allowed.
// RULE2: operational: run indicator steady on, pre-operational diagnostic input cleared.
// RULE3: prepared: no sdo or pdo traffic; leave only by nmt command.
// RULE4: after power-on send one boot-up frame on 1792 plus node address.
// RULE5: no process data before start remote node brings operational.
// RULE6: each entry to operational sends tx pdos of type 254 or 255.
// RULE7: any detected error moves the node to prepared, stopping sdo/pdo. Here an nmt command for this node in the same cycle wins over the error.
// RULE8: prepared obeys only nmt: start to operational, pre-op to pre-operational.
// RULE9: reset node/communication: init, reload saved or defaults, then pre-operational.
// RULE10: start, pre-op and reset commands with node id 0 also apply.
// RULE11: stop command, own id or id 0, enters prepared.
// RULE12: each guard poll is answered with current state. Here only in guard mode, so not when heartbeat time is nonzero or guard time or life factor is zero.
// RULE13: master flags guarding event when a node misses life time.
// RULE14: life time expiry: comm error, zero outputs, double-blink error indicator.
// RULE15: polling resumes: error indicator off at once, outputs pass again.
// RULE16: heartbeat sent cyclically at producer heartbeat time.
// RULE17: nonzero heartbeat time: first heartbeat at init to pre-operational.
// RULE18: heartbeat used when its time is nonzero; guarding then ignored.
// RULE19: heartbeat frames of other nodes are not consumed.
// RULE20: save signature to 1010 stores all communication parameters at once.
// RULE21: load signature to 1011 restores all factory defaults.
// RULE22: lss global and selective modes set node id, applied immediately.
// RULE23: pre-operational: sdo allowed, no pdo, no emergency.
// RULE24: after initialisation move to pre-operational unprompted.
// RULE25: state codes in guard answer and heartbeat use standard values.
module cnms_supervisor
  import cnms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic nmt_valid_i,
  input wire cnms_nmt_cmd_t nmt_cmd_i,
  input wire logic guard_poll_i,
  input wire logic err_detect_i,
  input wire logic od_wr_i,
  input wire logic [15:0] od_index_i,
  input wire logic [31:0] od_data_i,
  input wire cnms_params_t param_wr_i,
  input wire logic param_wr_en_i,
  input wire logic lss_valid_i,
  input wire logic [1:0] lss_mode_i,
  input wire logic lss_selected_i,
  input wire logic [6:0] lss_node_id_i,
  input wire logic [7:0] rx_pdo_data_i,
  input wire logic ec_ready_i,
  output logic ec_valid_o,
  output cnms_ec_frame_t ec_frame_o,
  output logic [6:0] node_id_o,
  output cnms_state_t state_o,
  output logic sdo_enable_o,
  output logic pdo_enable_o,
  output logic emcy_enable_o,
  output logic tpdo_kick_o,
  output logic [7:0] bd_out_o,
  output logic preop_diag_input_o,
  output logic run_led_o,
  output logic err_led_o,
  output logic comm_err_o,
  output cnms_params_t params_o,
  output logic nv_store_o,
  output cnms_params_t nv_image_o
);

  // ----------------------------------------------------------------
  // state and command decode
  // ----------------------------------------------------------------
  cnms_state_t state_q, state_d;
  logic [6:0] node_id_q;
  logic for_me, boot_q, hb_first_q, hb_tick, guard_fail_q, guard_mode;
  logic [6:0] st_code;
  cnms_params_t saved_q, live_q;
  logic saved_valid_q;

  // the address check honours broadcast id 0 as well as our own id
  assign for_me = nmt_valid_i && (nmt_cmd_i.node_id == 7'h00 || nmt_cmd_i.node_id == node_id_q); // RULE10 RULE11

  // next state; init falls through to pre-operational by itself
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CNMS_INIT: state_d = CNMS_PREOP; // RULE24 RULE9
      CNMS_PREOP, CNMS_OPER, CNMS_PREP:
      begin
        if (err_detect_i && state_q != CNMS_PREP)
        begin
          state_d = CNMS_PREP; // RULE7
        end
        if (for_me)
        begin
          case (nmt_cmd_i.cs)
            `CNMS_CS_START: state_d = CNMS_OPER; // RULE8 RULE5
            `CNMS_CS_STOP: state_d = CNMS_PREP; // RULE11 RULE3
            `CNMS_CS_PREOP: state_d = CNMS_PREOP; // RULE8
            `CNMS_CS_RST_NODE, `CNMS_CS_RST_COMM: state_d = CNMS_INIT; // RULE9
            default: state_d = state_d;
          endcase
        end
      end
      default: state_d = CNMS_INIT;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= CNMS_INIT;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // standard state codes for guard answers and heartbeat
  always_comb
  begin
    case (state_q)
      CNMS_PREOP: st_code = `CNMS_ST_PREOP; // RULE25
      CNMS_OPER: st_code = `CNMS_ST_OPER;
      CNMS_PREP: st_code = `CNMS_ST_STOPPED;
      default: st_code = `CNMS_ST_BOOT;
    endcase
  end

  // ----------------------------------------------------------------
  // communication enables and indicators
  // ----------------------------------------------------------------
  assign state_o = state_q;
  assign node_id_o = node_id_q;
  assign sdo_enable_o = (state_q == CNMS_PREOP) || (state_q == CNMS_OPER); // RULE3 RULE23
  assign pdo_enable_o = (state_q == CNMS_OPER); // RULE1 RULE5 RULE23
  assign emcy_enable_o = (state_q == CNMS_OPER); // RULE1 RULE23
  assign params_o = live_q;

  // pulse the tx pdo request on every entry into operational
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tpdo_kick_o <= 1'b0;
    end
    else
    begin
      tpdo_kick_o <= (state_d == CNMS_OPER) && (state_q != CNMS_OPER); // RULE6
    end
  end

  // blink time base: one enable pulse per blink phase
  localparam int unsigned BLINK_CYC = `CNMS_BLINK_MS * `CNMS_CYC_PER_MS;
  logic [24:0] blink_cnt_q;
  logic [2:0] blink_ph_q;
  logic blink_tick;
  assign blink_tick = (blink_cnt_q == 25'(BLINK_CYC - 1));

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      blink_cnt_q <= 25'h0;
      blink_ph_q <= 3'h0;
    end
    else
    begin
      blink_cnt_q <= blink_tick ? 25'h0 : blink_cnt_q + 25'h1;
      if (blink_tick)
      begin
        blink_ph_q <= blink_ph_q + 3'h1;
      end
    end
  end

  // run led: steady in operational, flashing in pre-operational
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      run_led_o <= 1'b0;
      preop_diag_input_o <= 1'b0;
      err_led_o <= 1'b0;
    end
    else
    begin
      run_led_o <= (state_q == CNMS_OPER) || (state_q == CNMS_PREOP && blink_ph_q[0]); // RULE2
      preop_diag_input_o <= (state_q == CNMS_PREOP); // RULE2
      // double blink: on in phases 0 and 2 of eight
      err_led_o <= guard_fail_q && (blink_ph_q == 3'h0 || blink_ph_q == 3'h2); // RULE14 RULE15
    end
  end

  // outputs to the basic device are zeroed while guarding has failed
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      bd_out_o <= 8'h00;
    end
    else if (guard_fail_q)
    begin
      bd_out_o <= 8'h00; // RULE14
    end
    else if (state_q == CNMS_OPER)
    begin
      bd_out_o <= rx_pdo_data_i; // RULE15 RULE5
    end
  end

  // ----------------------------------------------------------------
  // node guarding life time
  // ----------------------------------------------------------------
  logic [31:0] life_cnt_q;
  logic [31:0] life_ms;
  logic ms_tick;
  logic [16:0] ms_cnt_q;
  assign ms_tick = (ms_cnt_q == 17'(`CNMS_CYC_PER_MS - 1));
  assign life_ms = 32'(live_q.guard_ms) * 32'(live_q.life_factor);
  assign guard_mode = (live_q.hb_ms == 16'h0) && (life_ms != 32'h0); // RULE18
  assign comm_err_o = guard_fail_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ms_cnt_q <= 17'h0;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 17'h0 : ms_cnt_q + 17'h1;
    end
  end

  // guarding starts with the first poll; poll resumption clears the failure
  logic guard_armed_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || state_q == CNMS_INIT || !guard_mode)
    begin
      life_cnt_q <= 32'h0;
      guard_armed_q <= 1'b0;
      guard_fail_q <= 1'b0;
    end
    else if (guard_poll_i)
    begin
      life_cnt_q <= 32'h0;
      guard_armed_q <= 1'b1;
      guard_fail_q <= 1'b0; // RULE15
    end
    else if (guard_armed_q && ms_tick)
    begin
      if (life_cnt_q + 32'h1 >= life_ms)
      begin
        guard_fail_q <= 1'b1; // RULE14
      end
      else
      begin
        life_cnt_q <= life_cnt_q + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // heartbeat producer
  // ----------------------------------------------------------------
  logic [15:0] hb_cnt_q;
  assign hb_tick = (live_q.hb_ms != 16'h0) && ms_tick && (hb_cnt_q + 16'h1 >= live_q.hb_ms); // RULE16

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || state_q == CNMS_INIT)
    begin
      hb_cnt_q <= 16'h0;
    end
    else if (hb_tick)
    begin
      hb_cnt_q <= 16'h0;
    end
    else if (ms_tick)
    begin
      hb_cnt_q <= hb_cnt_q + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // error-control frame sender: boot-up, guard answer, heartbeat
  // ----------------------------------------------------------------
  logic hb_pend_q, guard_pend_q, toggle_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      boot_q <= 1'b0;
      hb_first_q <= 1'b0;
      hb_pend_q <= 1'b0;
      guard_pend_q <= 1'b0;
      toggle_q <= 1'b0;
      ec_valid_o <= 1'b0;
      ec_frame_o <= '0;
    end
    else
    begin
      if (state_q == CNMS_INIT)
      begin
        boot_q <= 1'b1; // RULE4
        hb_first_q <= (live_q.hb_ms != 16'h0); // RULE17
        toggle_q <= 1'b0;
      end
      if (ec_valid_o && ec_ready_i)
      begin
        ec_valid_o <= 1'b0;
      end
      else if (!ec_valid_o && state_q != CNMS_INIT)
      begin
        ec_frame_o.cob_id <= `CNMS_ERRCTL_BASE + 11'(node_id_q); // RULE4
        if (boot_q)
        begin
          ec_frame_o.data <= 8'h00;
          ec_valid_o <= 1'b1;
          boot_q <= 1'b0;
        end
        else if (guard_pend_q)
        begin
          ec_frame_o.data <= {toggle_q, st_code}; // RULE12 RULE25
          toggle_q <= ~toggle_q;
          ec_valid_o <= 1'b1;
          guard_pend_q <= 1'b0;
        end
        else if (hb_pend_q)
        begin
          ec_frame_o.data <= {1'b0, st_code}; // RULE16 RULE25
          ec_valid_o <= 1'b1;
          hb_pend_q <= 1'b0;
        end
      end
      // requests come after the sender so that a new one in the cycle of a send is kept
      // poll frames are answered only in guard mode; heartbeat frames of others never reach here
      if ((hb_tick || hb_first_q) && !boot_q)
      begin
        hb_pend_q <= 1'b1; // RULE16 RULE19
        hb_first_q <= 1'b0;
      end
      if (guard_poll_i && guard_mode)
      begin
        guard_pend_q <= 1'b1; // RULE12 RULE18
      end
    end
  end

  // ----------------------------------------------------------------
  // parameters: live set, save and restore
  // ----------------------------------------------------------------
  logic save_hit, load_hit;
  assign save_hit = od_wr_i && od_index_i == 16'h1010 && od_data_i == `CNMS_SIG_SAVE;
  assign load_hit = od_wr_i && od_index_i == 16'h1011 && od_data_i == `CNMS_SIG_LOAD;
  assign nv_image_o = saved_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      saved_q <= '0;
      saved_valid_q <= 1'b0;
      nv_store_o <= 1'b0;
      live_q <= '0;
    end
    else
    begin
      nv_store_o <= save_hit;
      if (save_hit)
      begin
        saved_q <= live_q; // RULE20
        saved_valid_q <= 1'b1;
      end
      if (state_q == CNMS_INIT)
      begin
        live_q <= saved_valid_q ? saved_q : '0; // RULE9
      end
      else if (load_hit)
      begin
        live_q <= '0; // RULE21
      end
      else if (param_wr_en_i && sdo_enable_o)
      begin
        live_q <= param_wr_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // layer setting service node id
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      node_id_q <= `CNMS_DEF_NODE_ID;
    end
    else if (lss_valid_i && lss_node_id_i != 7'h00 &&
             (lss_mode_i == `CNMS_LSS_GLOBAL || (lss_mode_i == `CNMS_LSS_SELECT && lss_selected_i)))
    begin
      node_id_q <= lss_node_id_i; // RULE22
    end
  end

endmodule : cnms_supervisor

// ---- core/cnms_map.svh ----
/*
  constants for the nmt node supervisor: frame identifiers, command specifiers,
  state codes, signatures, timing counts.
  assumes a 100 MHz node clock.
*/
`ifndef CNMS_MAP_SVH
`define CNMS_MAP_SVH
`define CNMS_ERRCTL_BASE 11'h700
`define CNMS_CS_START 8'h01
`define CNMS_CS_STOP 8'h02
`define CNMS_CS_PREOP 8'h80
`define CNMS_CS_RST_NODE 8'h81
`define CNMS_CS_RST_COMM 8'h82
`define CNMS_ST_BOOT 7'h00
`define CNMS_ST_STOPPED 7'h04
`define CNMS_ST_OPER 7'h05
`define CNMS_ST_PREOP 7'h7f
`define CNMS_SIG_SAVE 32'h65766173
`define CNMS_SIG_LOAD 32'h64616f6c
`define CNMS_CLK_MHZ 100
`define CNMS_MS_NS 1000000
`define CNMS_CYC_PER_MS (`CNMS_MS_NS / (1000 / `CNMS_CLK_MHZ))
`define CNMS_BLINK_MS 200
`define CNMS_DEF_NODE_ID 7'h01
`define CNMS_LSS_GLOBAL 2'h1
`define CNMS_LSS_SELECT 2'h2
`endif

// ---- core/cnms_pkg.sv ----
/*
  types of the nmt node supervisor.
  assumes nothing beyond the map header.
*/
package cnms_pkg;
  typedef enum logic [1:0] {
    CNMS_INIT = 2'b00,
    CNMS_PREOP = 2'b01,
    CNMS_OPER = 2'b10,
    CNMS_PREP = 2'b11
  } cnms_state_t;

  // one received nmt command frame
  typedef struct packed {
    logic [7:0] cs;
    logic [6:0] node_id;
  } cnms_nmt_cmd_t;

  // one frame offered on the error-control identifier
  typedef struct packed {
    logic [10:0] cob_id;
    logic [7:0] data;
  } cnms_ec_frame_t;

  // communication parameters kept across resets
  typedef struct packed {
    logic [15:0] guard_ms;
    logic [7:0] life_factor;
    logic [15:0] hb_ms;
  } cnms_params_t;
endpackage : cnms_pkg

// ---- testbench/cnms_sv_chk.sv ----
/*
  port assertions for the nmt node supervisor.
  assumes it is bound onto cnms_supervisor.
*/
`timescale 1ns/100ps
`include "cnms_map.svh"
module cnms_sv_chk
  import cnms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic nmt_valid_i,
  input wire cnms_nmt_cmd_t nmt_cmd_i,
  input wire logic err_detect_i,
  input wire logic lss_valid_i,
  input wire logic [1:0] lss_mode_i,
  input wire logic lss_selected_i,
  input wire logic [6:0] lss_node_id_i,
  input wire logic ec_ready_i,
  input wire logic ec_valid_o,
  input wire cnms_ec_frame_t ec_frame_o,
  input wire logic [6:0] node_id_o,
  input wire cnms_state_t state_o,
  input wire logic sdo_enable_o,
  input wire logic pdo_enable_o,
  input wire logic emcy_enable_o,
  input wire logic tpdo_kick_o,
  input wire logic run_led_o,
  input wire logic preop_diag_input_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // command that addresses this node, by own id or broadcast
  logic own;
  assign own = nmt_valid_i && !err_detect_i && state_o != CNMS_INIT &&
    (nmt_cmd_i.node_id == 7'h00 || nmt_cmd_i.node_id == node_id_o);
  a_oper_full: assert property (state_o == CNMS_OPER |-> sdo_enable_o && pdo_enable_o && emcy_enable_o)
    else $error("operational without full traffic");
  a_pdo_gate: assert property (pdo_enable_o |-> state_o == CNMS_OPER)
    else $error("pdo enabled outside operational");
  a_oper_leds: assert property (state_o == CNMS_OPER [*2] |-> run_led_o && !preop_diag_input_o)
    else $error("run indicator or diag input wrong");
  a_prep_quiet: assert property (state_o == CNMS_PREP |-> !sdo_enable_o && !pdo_enable_o && !emcy_enable_o)
    else $error("traffic enabled while prepared");
  a_preop_sdo: assert property (state_o == CNMS_PREOP |-> sdo_enable_o && !pdo_enable_o && !emcy_enable_o)
    else $error("pre-operational enables wrong");
  a_start_kick: assert property (own && nmt_cmd_i.cs == `CNMS_CS_START && state_o != CNMS_OPER
    |=> state_o == CNMS_OPER && tpdo_kick_o)
    else $error("start did not reach operational with pdo kick");
  a_stop_prep: assert property (own && nmt_cmd_i.cs == `CNMS_CS_STOP |=> state_o == CNMS_PREP)
    else $error("stop did not reach prepared");
  a_reset_init: assert property (own && nmt_cmd_i.cs inside {`CNMS_CS_RST_NODE, `CNMS_CS_RST_COMM}
    |=> state_o == CNMS_INIT ##1 state_o == CNMS_PREOP)
    else $error("reset command sequence wrong");
  a_err_prep: assert property (err_detect_i && !nmt_valid_i && state_o inside {CNMS_PREOP, CNMS_OPER}
    |=> state_o == CNMS_PREP)
    else $error("error did not force prepared");
  a_ec_hold: assert property (ec_valid_o && !ec_ready_i |=> ec_valid_o && $stable(ec_frame_o))
    else $error("offered frame dropped or changed");
  a_ec_cob: assert property (ec_valid_o |-> ec_frame_o.cob_id == `CNMS_ERRCTL_BASE + node_id_o)
    else $error("error-control identifier wrong");
  a_lss_apply: assert property (lss_valid_i && lss_node_id_i != 7'h00 && (lss_mode_i == `CNMS_LSS_GLOBAL
    || (lss_mode_i == `CNMS_LSS_SELECT && lss_selected_i)) |=> node_id_o == $past(lss_node_id_i))
    else $error("node id not applied");
endmodule : cnms_sv_chk
bind cnms_supervisor cnms_sv_chk chk (.clk_i, .rst_n_i, .nmt_valid_i, .nmt_cmd_i, .err_detect_i, .lss_valid_i,
  .lss_mode_i, .lss_selected_i, .lss_node_id_i, .ec_ready_i, .ec_valid_o, .ec_frame_o, .node_id_o, .state_o,
  .sdo_enable_o, .pdo_enable_o, .emcy_enable_o, .tpdo_kick_o, .run_led_o, .preop_diag_input_o);

// ---- testbench/cnms_master_model.sv ----
/*
  master side of the error-control channel: takes frames, keeps the last.
  assumes the node offers frames on a valid/ready pair.
*/
`timescale 1ns/100ps
module cnms_master_model
  import cnms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic ec_valid_i,
  input wire cnms_ec_frame_t ec_frame_i,
  output logic ec_ready_o,
  output logic [7:0] cnt_o,
  output cnms_ec_frame_t last_o
);
  logic [1:0] wait_q;
  // accept at once, or after idle cycles when slow
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ec_ready_o <= 1'b0;
      wait_q <= 2'h0;
      cnt_o <= 8'h00;
      last_o <= '0;
    end
    else if (ec_valid_i && ec_ready_o)
    begin
      ec_ready_o <= 1'b0;
      wait_q <= 2'h0;
      cnt_o <= cnt_o + 8'h01;
      last_o <= ec_frame_i;
    end
    else if (ec_valid_i && (!slow_i || wait_q == 2'h3))
      ec_ready_o <= 1'b1;
    else if (ec_valid_i)
      wait_q <= wait_q + 2'h1;
  end
endmodule : cnms_master_model

// ---- testbench/cnms_supervisor_test.sv ----
/*
  self-checking bench for the nmt node supervisor.
  assumes the master model takes every error-control frame.
*/
`timescale 1ns/100ps
`include "cnms_map.svh"
module cnms_supervisor_test
  import cnms_pkg::*;
  ;
  localparam logic [10:0] ID1 = `CNMS_ERRCTL_BASE + `CNMS_DEF_NODE_ID;
  logic clk_i = 0, rst_n_i = 0, nmt_valid_i = 0, guard_poll_i = 0, err_detect_i = 0, od_wr_i = 0;
  logic param_wr_en_i = 0, lss_valid_i = 0, lss_selected_i = 0, ec_ready_i, slow = 0, hit;
  cnms_nmt_cmd_t nmt_cmd_i = '0;
  logic [15:0] od_index_i = '0;
  logic [31:0] od_data_i = '0;
  cnms_params_t param_wr_i = '0, params_o, nv_image_o;
  logic [1:0] lss_mode_i = '0;
  logic [6:0] lss_node_id_i = '0, node_id_o;
  logic [7:0] rx_pdo_data_i = '0, ec_cnt, n0, bd_out_o;
  logic ec_valid_o, tpdo_kick_o, preop_diag_input_o, run_led_o, err_led_o, comm_err_o, nv_store_o;
  logic sdo_enable_o, pdo_enable_o, emcy_enable_o;
  cnms_ec_frame_t ec_frame_o, last;
  cnms_state_t state_o;
  int errors = 0, n_tests = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  cnms_supervisor uut (.clk_i, .rst_n_i, .nmt_valid_i, .nmt_cmd_i, .guard_poll_i, .err_detect_i, .od_wr_i,
    .od_index_i, .od_data_i, .param_wr_i, .param_wr_en_i, .lss_valid_i, .lss_mode_i, .lss_selected_i,
    .lss_node_id_i, .rx_pdo_data_i, .ec_ready_i, .ec_valid_o, .ec_frame_o, .node_id_o, .state_o,
    .sdo_enable_o, .pdo_enable_o, .emcy_enable_o, .tpdo_kick_o, .bd_out_o, .preop_diag_input_o,
    .run_led_o, .err_led_o, .comm_err_o, .params_o, .nv_store_o, .nv_image_o);
  cnms_master_model mst (.clk_i, .rst_n_i, .slow_i(slow), .ec_valid_i(ec_valid_o), .ec_frame_i(ec_frame_o),
    .ec_ready_o(ec_ready_i), .cnt_o(ec_cnt), .last_o(last));
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task chk(input logic [39:0] g, input logic [39:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one strobe (0 nmt, 1 poll, 2 error, 3 object write, 4 params, 5 lss) with its data
  task pulse(input int k, input logic [47:0] d);
    @(posedge clk_i);
    {nmt_valid_i, guard_poll_i, err_detect_i} <= {k == 0, k == 1, k == 2};
    {od_wr_i, param_wr_en_i, lss_valid_i} <= {k == 3, k == 4, k == 5};
    nmt_cmd_i <= d[14:0];
    {od_index_i, od_data_i} <= d;
    param_wr_i <= d[39:0];
    {lss_mode_i, lss_selected_i, lss_node_id_i} <= d[9:0];
    @(posedge clk_i);
    {nmt_valid_i, guard_poll_i, err_detect_i, od_wr_i, param_wr_en_i, lss_valid_i} <= 6'h00;
    #1;
  endtask : pulse
  task wait_ec;
    n0 = ec_cnt;
    for (int i = 0; i < 50 && ec_cnt == n0; i++)
      step(1);
  endtask : wait_ec
  task t_boot;
    step(8);
    chk(last, {ID1, 8'h00});
    chk(ec_cnt, 8'h01);
    chk(state_o, CNMS_PREOP);
    $display("test boot done");
  endtask : t_boot
  task t_nmt;
    pulse(0, {`CNMS_CS_START, 7'h01});
    chk(pdo_enable_o, 1'b1);
    chk(tpdo_kick_o, 1'b1);
    step(1);
    chk(tpdo_kick_o, 1'b0);
    chk({run_led_o, preop_diag_input_o}, 2'b10);
    pulse(0, {`CNMS_CS_STOP, 7'h00});
    chk(state_o, CNMS_PREP);
    pulse(2, 0);
    pulse(0, {`CNMS_CS_PREOP, 7'h00});
    chk(state_o, CNMS_PREOP);
    pulse(0, {`CNMS_CS_START, 7'h02});
    chk(state_o, CNMS_PREOP);
    pulse(2, 0);
    chk(state_o, CNMS_PREP);
    pulse(0, {`CNMS_CS_START, 7'h00});
    chk(state_o, CNMS_OPER);
    $display("test nmt done");
  endtask : t_nmt
  task t_guard;
    @(posedge clk_i);
    rx_pdo_data_i <= 8'h5a;
    pulse(4, 40'h0001_01_0000);
    pulse(1, 0);
    wait_ec;
    chk(last, {ID1, 8'h05});
    slow <= 1'b1;
    pulse(1, 0);
    wait_ec;
    chk(last, {ID1, 8'h85});
    chk(bd_out_o, 8'h5a);
    n0 = ec_cnt;
    step(100050);
    chk(ec_cnt, n0);
    chk({comm_err_o, err_led_o, bd_out_o}, 10'h300);
    pulse(1, 0);
    step(1);
    chk({err_led_o, bd_out_o}, 9'h05a);
    wait_ec;
    chk(last, {ID1, 8'h05});
    $display("test guard done");
  endtask : t_guard
  task t_save;
    pulse(0, {`CNMS_CS_PREOP, 7'h01});
    pulse(4, 40'h0001_01_0003);
    n0 = ec_cnt;
    pulse(1, 0);
    step(20);
    chk(ec_cnt, n0);
    pulse(3, {16'h1010, `CNMS_SIG_SAVE});
    chk(nv_store_o, 1'b1);
    step(3);
    chk(nv_image_o, 40'h0001_01_0003);
    pulse(0, {`CNMS_CS_RST_NODE, 7'h00});
    hit = 1'b0;
    for (int i = 0; i < 30; i++)
    begin
      step(1);
      hit = hit | (last === {ID1, 8'h7f});
    end
    chk(hit, 1'b1);
    chk(params_o.hb_ms, 16'h0003);
    pulse(3, {16'h1011, `CNMS_SIG_LOAD});
    step(2);
    chk(params_o, 40'h0);
    $display("test save done");
  endtask : t_save
  task t_lss;
    pulse(5, {`CNMS_LSS_GLOBAL, 1'b0, 7'h05});
    chk(node_id_o, 7'h05);
    pulse(5, {`CNMS_LSS_SELECT, 1'b0, 7'h09});
    chk(node_id_o, 7'h05);
    pulse(5, {`CNMS_LSS_SELECT, 1'b1, 7'h09});
    chk(node_id_o, 7'h09);
    pulse(0, {`CNMS_CS_START, 7'h09});
    chk(state_o, CNMS_OPER);
    $display("test lss done");
  endtask : t_lss
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // cut a hang short
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 150000)
    begin
      errors++;
      end_sim;
    end
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_boot;
    t_nmt;
    t_guard;
    t_save;
    t_lss;
    end_sim;
  end
endmodule : cnms_supervisor_test
